// ===== ufsr_pkg.sv
// Notes on behaviour
// - A transmitted resume character sets the transmit-resume flag, and a read clears it.
// - A transmitted pause character sets the transmit-pause flag, and a read clears it.
// - A received resume character sets the receive-resume flag, and a read clears it.
// - A received pause character sets the receive-pause flag, and a read clears it.
// - While software flow control is off, the read-only flow status is forced to zero; bits 7:4 read zero.
// - The divisor latches load low 0x01 and high 0x00 at power-up only; the reset pin leaves them alone.
// - Reset clears the low four modem status bits and loads the upper four with the modem input levels.
// - Reset loads irq status with 0x01, line status with 0x60 and scratch with 0xff; the holding registers stay undefined.
// - Reset drives the serial transmit, request-to-send and terminal-ready outputs high.
// - The low four bits of the enhanced feature register select software flow control; all zero means none.
package ufsr_pkg;
	// ----------------------------------------
	// register offsets
	// ----------------------------------------
	localparam logic [4:0] ADDR_DIV_LOW = 5'h00;
	localparam logic [4:0] ADDR_DIV_HIGH = 5'h01;
	localparam logic [4:0] ADDR_DIV_FRAC = 5'h02;
	localparam logic [4:0] ADDR_IRQ_EN = 5'h03;
	localparam logic [4:0] ADDR_FIFO_CTL = 5'h04;
	localparam logic [4:0] ADDR_IRQ_STAT = 5'h05;
	localparam logic [4:0] ADDR_LINE_CTL = 5'h06;
	localparam logic [4:0] ADDR_MODEM_CTL = 5'h07;
	localparam logic [4:0] ADDR_LINE_STAT = 5'h08;
	localparam logic [4:0] ADDR_MODEM_STAT = 5'h09;
	localparam logic [4:0] ADDR_SCRATCH = 5'h0a;
	localparam logic [4:0] ADDR_FEAT_CTL = 5'h0b;
	localparam logic [4:0] ADDR_ENH_FEAT = 5'h0c;
	localparam logic [4:0] ADDR_TX_CNT = 5'h0d;
	localparam logic [4:0] ADDR_TX_TRG = 5'h0e;
	localparam logic [4:0] ADDR_RX_CNT = 5'h0f;
	localparam logic [4:0] ADDR_RX_TRG = 5'h10;
	localparam logic [4:0] ADDR_FLOW_STAT = 5'h11;
	localparam logic [4:0] ADDR_RESUME1 = 5'h12;
	localparam logic [4:0] ADDR_RESUME2 = 5'h13;
	localparam logic [4:0] ADDR_PAUSE1 = 5'h14;
	localparam logic [4:0] ADDR_PAUSE2 = 5'h15;
	localparam logic [4:0] ADDR_HOLDING = 5'h16;
	// ----------------------------------------
	// reset values and fields
	// ----------------------------------------
	localparam logic [7:0] DIV_LOW_POR = 8'h01;
	localparam logic [7:0] DIV_HIGH_POR = 8'h00;
	localparam logic [7:0] ZERO_RST = 8'h00;
	localparam logic [7:0] IRQ_STAT_RST = 8'h01;
	localparam logic [7:0] LINE_STAT_RST = 8'h60;
	localparam logic [7:0] SCRATCH_RST = 8'hff;
	localparam logic [3:0] NIBBLE_ZERO = 4'h0;
	localparam logic [3:0] FLOW_NONE = 4'h0;
	localparam int FS_TX_ON = 3;
	localparam int FS_TX_OFF = 2;
	localparam int FS_RX_ON = 1;
	localparam int FS_RX_OFF = 0;
	localparam int MCR_DTR = 0;
	localparam int MCR_RTS = 1;
	// ----------------------------------------
	// carriers
	// ----------------------------------------
	typedef struct packed {
		logic sel;
		logic rd;
		logic wr;
		logic [4:0] addr;
		logic [7:0] wdata;
	} ufsr_bus_t;
	typedef struct packed {
		logic tx_on;
		logic tx_off;
		logic rx_on;
		logic rx_off;
	} ufsr_flow_evt_t;
	typedef struct packed {
		logic cd;
		logic ri;
		logic dsr;
		logic cts;
	} ufsr_modem_t;
endpackage : ufsr_pkg

// ===== ufsr_flow_stat.sv
`timescale 1ns/1ps
module ufsr_flow_stat import ufsr_pkg::*; (
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic srst_in,
	// control
	input wire logic sw_flow_en_in,
	input wire logic rd_clr_in,
	input wire ufsr_flow_evt_t evt_in,
	// status
	output logic [3:0] status_out
);
	logic [3:0] status_reg;
	logic [3:0] status_next;
	wire tx_any = evt_in.tx_on | evt_in.tx_off;
	wire rx_any = evt_in.rx_on | evt_in.rx_off;
	wire [3:0] set_mask = {evt_in.tx_on, evt_in.tx_off, evt_in.rx_on, evt_in.rx_off};
	// a newer character of one direction replaces the older flag of that direction
	wire [3:0] clr_mask = {4{rd_clr_in}} | {tx_any, tx_any, rx_any, rx_any};
	// set wins over the read clear so an event in the read cycle survives
	assign status_next = sw_flow_en_in ? ((status_reg & ~clr_mask) | set_mask) : NIBBLE_ZERO;
	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			status_reg <= NIBBLE_ZERO;
		end else begin
			status_reg <= status_next;
		end
	end
	assign status_out = status_reg;
	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (srst_in);
	a_fs_tx_on: assert property (sw_flow_en_in && evt_in.tx_on |=> status_out[FS_TX_ON])
		else $error("tx resume flag not set");
	a_fs_tx_off: assert property (sw_flow_en_in && evt_in.tx_off && !evt_in.tx_on
		|=> status_out[FS_TX_OFF] && !status_out[FS_TX_ON])
		else $error("tx pause flag wrong");
	a_fs_rx_on: assert property (sw_flow_en_in && rd_clr_in && evt_in.rx_on |=> status_out[FS_RX_ON])
		else $error("rx resume lost on read");
	a_fs_rx_off: assert property (sw_flow_en_in && evt_in.rx_off && !evt_in.rx_on
		|=> status_out[FS_RX_OFF] && !status_out[FS_RX_ON])
		else $error("rx pause flag wrong");
	a_fs_read_clear: assert property (sw_flow_en_in && rd_clr_in && !tx_any && !rx_any
		|=> status_out == NIBBLE_ZERO)
		else $error("read did not clear flags");
	a_fs_disabled_zero: assert property (!sw_flow_en_in |=> status_out == NIBBLE_ZERO)
		else $error("flags held while flow control off");
endmodule : ufsr_flow_stat

// ===== ufsr_regs.sv
`timescale 1ns/1ps
module ufsr_regs import ufsr_pkg::*; (
	// clock and resets
	input wire logic ref_clk_in,
	input wire logic srst_in,
	input wire logic por_in,
	// register bus
	input wire ufsr_bus_t bus_in,
	output logic [7:0] rdata_out,
	// channel status from the uart core
	input wire logic [7:0] irq_status_in,
	input wire logic [7:0] line_status_in,
	input wire logic [7:0] rx_data_in,
	input wire logic [7:0] tx_fifo_count_in,
	input wire logic [7:0] rx_fifo_count_in,
	input wire ufsr_flow_evt_t flow_evt_in,
	input wire logic serial_tx_in,
	// modem inputs
	input wire ufsr_modem_t modem_in,
	// serial and modem outputs
	output logic tx_out,
	output logic rts_n_out,
	output logic dtr_n_out,
	// to the uart core
	output logic tx_load_out,
	output logic [7:0] tx_data_out,
	output logic [3:0] flow_mode_out,
	output logic [3:0] flow_status_out
);
	// ----------------------------------------
	// storage
	// ----------------------------------------
	logic [7:0] div_low_reg, div_high_reg, div_frac_reg, irq_enable_reg, fifo_control_reg;
	logic [7:0] irq_status_reg, line_control_reg, modem_control_reg, line_status_reg;
	logic [7:0] modem_status_reg, modem_status_next, scratch_reg, feature_control_reg;
	logic [7:0] enhanced_feature_reg, tx_fifo_count_reg, tx_fifo_trigger_reg;
	logic [7:0] rx_fifo_count_reg, rx_fifo_trigger_reg;
	logic [7:0] resume_char_first_reg, resume_char_second_reg;
	logic [7:0] pause_char_first_reg, pause_char_second_reg;
	logic [7:0] tx_holding_reg, rx_holding_reg, rdata_reg, rdata_next;
	logic [3:0] modem_prev_reg;
	logic tx_reg, rts_n_reg, dtr_n_reg, tx_load_reg;
	// ----------------------------------------
	// decode
	// ----------------------------------------
	wire rst_all = srst_in | por_in;
	wire wr_go = bus_in.sel & bus_in.wr;
	wire rd_go = bus_in.sel & bus_in.rd;
	wire we_div_low = wr_go && bus_in.addr == ADDR_DIV_LOW;
	wire we_div_high = wr_go && bus_in.addr == ADDR_DIV_HIGH;
	wire we_div_frac = wr_go && bus_in.addr == ADDR_DIV_FRAC;
	wire we_irq_en = wr_go && bus_in.addr == ADDR_IRQ_EN;
	wire we_fifo_ctl = wr_go && bus_in.addr == ADDR_FIFO_CTL;
	wire we_line_ctl = wr_go && bus_in.addr == ADDR_LINE_CTL;
	wire we_modem_ctl = wr_go && bus_in.addr == ADDR_MODEM_CTL;
	wire we_scratch = wr_go && bus_in.addr == ADDR_SCRATCH;
	wire we_feat_ctl = wr_go && bus_in.addr == ADDR_FEAT_CTL;
	wire we_enh_feat = wr_go && bus_in.addr == ADDR_ENH_FEAT;
	wire we_tx_trg = wr_go && bus_in.addr == ADDR_TX_TRG;
	wire we_rx_trg = wr_go && bus_in.addr == ADDR_RX_TRG;
	wire we_resume1 = wr_go && bus_in.addr == ADDR_RESUME1;
	wire we_resume2 = wr_go && bus_in.addr == ADDR_RESUME2;
	wire we_pause1 = wr_go && bus_in.addr == ADDR_PAUSE1;
	wire we_pause2 = wr_go && bus_in.addr == ADDR_PAUSE2;
	wire we_holding = wr_go && bus_in.addr == ADDR_HOLDING;
	wire rd_flow_stat = rd_go && bus_in.addr == ADDR_FLOW_STAT;
	wire rd_modem_stat = rd_go && bus_in.addr == ADDR_MODEM_STAT;
	wire sw_flow_en = enhanced_feature_reg[3:0] != FLOW_NONE;
	wire [3:0] modem_lvl = modem_in;
	// delta bits: a change sets, a read clears, set wins
	wire [3:0] modem_delta = modem_lvl ^ modem_prev_reg;
	wire [3:0] delta_keep = rd_modem_stat ? NIBBLE_ZERO : modem_status_reg[3:0];
	assign modem_status_next = {modem_lvl, delta_keep | modem_delta};
	// ----------------------------------------
	// flow character status
	// ----------------------------------------
	ufsr_flow_stat u_flow_stat (
		.ref_clk_in(ref_clk_in),
		.srst_in(rst_all),
		.sw_flow_en_in(sw_flow_en),
		.rd_clr_in(rd_flow_stat),
		.evt_in(flow_evt_in),
		.status_out(flow_status_out)
	);
	// ----------------------------------------
	// read select
	// ----------------------------------------
	always_comb begin
		unique case (bus_in.addr)
			ADDR_DIV_LOW: rdata_next = div_low_reg;
			ADDR_DIV_HIGH: rdata_next = div_high_reg;
			ADDR_DIV_FRAC: rdata_next = div_frac_reg;
			ADDR_IRQ_EN: rdata_next = irq_enable_reg;
			ADDR_FIFO_CTL: rdata_next = fifo_control_reg;
			ADDR_IRQ_STAT: rdata_next = irq_status_reg;
			ADDR_LINE_CTL: rdata_next = line_control_reg;
			ADDR_MODEM_CTL: rdata_next = modem_control_reg;
			ADDR_LINE_STAT: rdata_next = line_status_reg;
			ADDR_MODEM_STAT: rdata_next = modem_status_reg;
			ADDR_SCRATCH: rdata_next = scratch_reg;
			ADDR_FEAT_CTL: rdata_next = feature_control_reg;
			ADDR_ENH_FEAT: rdata_next = enhanced_feature_reg;
			ADDR_TX_CNT: rdata_next = tx_fifo_count_reg;
			ADDR_TX_TRG: rdata_next = tx_fifo_trigger_reg;
			ADDR_RX_CNT: rdata_next = rx_fifo_count_reg;
			ADDR_RX_TRG: rdata_next = rx_fifo_trigger_reg;
			ADDR_FLOW_STAT: rdata_next = {NIBBLE_ZERO, flow_status_out};
			ADDR_RESUME1: rdata_next = resume_char_first_reg;
			ADDR_RESUME2: rdata_next = resume_char_second_reg;
			ADDR_PAUSE1: rdata_next = pause_char_first_reg;
			ADDR_PAUSE2: rdata_next = pause_char_second_reg;
			ADDR_HOLDING: rdata_next = rx_holding_reg;
			default: rdata_next = ZERO_RST;
		endcase
	end
	// ----------------------------------------
	// divisor latches: power-up only
	// ----------------------------------------
	always_ff @(posedge ref_clk_in) begin
		if (por_in) begin
			div_low_reg <= DIV_LOW_POR;
			div_high_reg <= DIV_HIGH_POR;
		end else begin
			if (we_div_low) div_low_reg <= bus_in.wdata;
			if (we_div_high) div_high_reg <= bus_in.wdata;
		end
	end
	// ----------------------------------------
	// holding registers: never reset, undefined until used
	// ----------------------------------------
	always_ff @(posedge ref_clk_in) begin
		if (we_holding) tx_holding_reg <= bus_in.wdata;
		rx_holding_reg <= rx_data_in;
	end
	// ----------------------------------------
	// control registers
	// ----------------------------------------
	always_ff @(posedge ref_clk_in) begin
		if (rst_all) begin
			{div_frac_reg, irq_enable_reg, fifo_control_reg, line_control_reg} <= {4{ZERO_RST}};
			{modem_control_reg, feature_control_reg, enhanced_feature_reg} <= {3{ZERO_RST}};
			{tx_fifo_trigger_reg, rx_fifo_trigger_reg} <= {2{ZERO_RST}};
			{resume_char_first_reg, resume_char_second_reg} <= {2{ZERO_RST}};
			{pause_char_first_reg, pause_char_second_reg} <= {2{ZERO_RST}};
			scratch_reg <= SCRATCH_RST;
		end else begin
			if (we_div_frac) div_frac_reg <= bus_in.wdata;
			if (we_irq_en) irq_enable_reg <= bus_in.wdata;
			if (we_fifo_ctl) fifo_control_reg <= bus_in.wdata;
			if (we_line_ctl) line_control_reg <= bus_in.wdata;
			if (we_modem_ctl) modem_control_reg <= bus_in.wdata;
			if (we_feat_ctl) feature_control_reg <= bus_in.wdata;
			if (we_enh_feat) enhanced_feature_reg <= bus_in.wdata;
			if (we_tx_trg) tx_fifo_trigger_reg <= bus_in.wdata;
			if (we_rx_trg) rx_fifo_trigger_reg <= bus_in.wdata;
			if (we_resume1) resume_char_first_reg <= bus_in.wdata;
			if (we_resume2) resume_char_second_reg <= bus_in.wdata;
			if (we_pause1) pause_char_first_reg <= bus_in.wdata;
			if (we_pause2) pause_char_second_reg <= bus_in.wdata;
			if (we_scratch) scratch_reg <= bus_in.wdata;
		end
	end
	// ----------------------------------------
	// status registers and outputs
	// ----------------------------------------
	always_ff @(posedge ref_clk_in) begin
		if (rst_all) begin
			irq_status_reg <= IRQ_STAT_RST;
			line_status_reg <= LINE_STAT_RST;
			{tx_fifo_count_reg, rx_fifo_count_reg} <= {2{ZERO_RST}};
			modem_status_reg <= {modem_lvl, NIBBLE_ZERO};
			modem_prev_reg <= modem_lvl;
			{tx_reg, rts_n_reg, dtr_n_reg} <= 3'h7;
			tx_load_reg <= 1'b0;
			rdata_reg <= ZERO_RST;
		end else begin
			irq_status_reg <= irq_status_in;
			line_status_reg <= line_status_in;
			tx_fifo_count_reg <= tx_fifo_count_in;
			rx_fifo_count_reg <= rx_fifo_count_in;
			modem_status_reg <= modem_status_next;
			modem_prev_reg <= modem_lvl;
			tx_reg <= serial_tx_in;
			rts_n_reg <= ~modem_control_reg[MCR_RTS];
			dtr_n_reg <= ~modem_control_reg[MCR_DTR];
			tx_load_reg <= we_holding;
			rdata_reg <= rd_go ? rdata_next : ZERO_RST;
		end
	end
	assign rdata_out = rdata_reg;
	assign tx_out = tx_reg;
	assign rts_n_out = rts_n_reg;
	assign dtr_n_out = dtr_n_reg;
	assign tx_load_out = tx_load_reg;
	assign tx_data_out = tx_holding_reg;
	assign flow_mode_out = enhanced_feature_reg[3:0];
	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence s_flow_read;
		rd_go && bus_in.addr == ADDR_FLOW_STAT;
	endsequence
	sequence s_pin_reset;
		srst_in && !por_in;
	endsequence
	a_div_pin_keep: assert property (@(posedge ref_clk_in) s_pin_reset
		|=> div_low_reg == $past(div_low_reg) && div_high_reg == $past(div_high_reg))
		else $error("divisor changed on reset pin");
	a_div_por_load: assert property (@(posedge ref_clk_in) por_in
		|=> div_low_reg == DIV_LOW_POR && div_high_reg == DIV_HIGH_POR)
		else $error("divisor not loaded at power-up");
	a_msr_reset: assert property (@(posedge ref_clk_in) rst_all
		|=> modem_status_reg[3:0] == NIBBLE_ZERO && modem_status_reg[7:4] == $past(modem_lvl))
		else $error("modem status reset wrong");
	a_stat_reset_vals: assert property (@(posedge ref_clk_in) rst_all |=> irq_status_reg == IRQ_STAT_RST
		&& line_status_reg == LINE_STAT_RST && scratch_reg == SCRATCH_RST)
		else $error("status reset values wrong");
	a_pins_reset_high: assert property (@(posedge ref_clk_in) rst_all[*2]
		|-> tx_out && rts_n_out && dtr_n_out)
		else $error("serial outputs not high in reset");
	a_ctrl_reset_zero: assert property (@(posedge ref_clk_in) rst_all |=> enhanced_feature_reg == ZERO_RST
		&& modem_control_reg == ZERO_RST && pause_char_second_reg == ZERO_RST)
		else $error("control reset not zero");
	a_flow_select: assert property (@(posedge ref_clk_in) disable iff (rst_all)
		flow_mode_out == FLOW_NONE |=> flow_status_out == NIBBLE_ZERO)
		else $error("flow status active with no flow mode");
	a_flow_read_data: assert property (@(posedge ref_clk_in) disable iff (rst_all)
		s_flow_read |=> rdata_out == {NIBBLE_ZERO, $past(flow_status_out)})
		else $error("flow status read data wrong");
endmodule : ufsr_regs

// ===== ufsr_host.sv
`timescale 1ns/1ps
module ufsr_host import ufsr_pkg::*; (
	// clock
	input wire logic ref_clk_in,
	// register bus
	output ufsr_bus_t bus_out,
	input wire logic [7:0] rdata_in
);
	initial bus_out = '{1'h0, 1'h0, 1'h0, 5'h1f, 8'ha5};
	// ----------------------------------------
	// one access: drive on a falling edge, held over the taking edge
	// ----------------------------------------
	task automatic access(input logic wr, input logic [4:0] addr, input logic [7:0] wdata,
			output logic [7:0] rdata);
		@(negedge ref_clk_in);
		bus_out = '{1'h1, ~wr, wr, addr, wdata};
		@(negedge ref_clk_in);
		rdata = rdata_in;
		// idle bus shows inverted leftovers, so stale fields never look valid
		bus_out = '{1'h0, 1'h0, 1'h0, ~addr, ~wdata};
	endtask : access
endmodule : ufsr_host

// ===== uart_flow_status_and_reset_state_tb.sv
`timescale 1ns/1ps
`define CHK(g, e) check((g) === (e), $sformatf("got %h want %h", g, e))
module uart_flow_status_and_reset_state_tb import ufsr_pkg::*;;
	typedef struct packed {logic [4:0] a; logic w; logic [7:0] d; logic [7:0] e;} ufsr_row_t;
	logic ref_clk_in, srst_in, por_in, serial_tx_in, tx_out, rts_n_out, dtr_n_out, tx_load_out;
	logic [7:0] rdata_out, irq_status_in, line_status_in, rx_data_in, tx_data_out;
	logic [7:0] tx_fifo_count_in, rx_fifo_count_in;
	logic [3:0] flow_mode_out, flow_status_out;
	ufsr_bus_t bus;
	ufsr_flow_evt_t flow_evt_in;
	ufsr_modem_t modem_in;
	int errors = 0;
	int n_compared = 0;
	int cycles = 0;
	ufsr_row_t rows [27] = '{
		'{ADDR_DIV_LOW, 1'h0, 8'h00, DIV_LOW_POR}, '{ADDR_DIV_HIGH, 1'h0, 8'h00, DIV_HIGH_POR},
		'{ADDR_DIV_FRAC, 1'h0, 8'h00, ZERO_RST}, '{ADDR_IRQ_EN, 1'h0, 8'h00, ZERO_RST},
		'{ADDR_FIFO_CTL, 1'h0, 8'h00, ZERO_RST}, '{ADDR_LINE_CTL, 1'h0, 8'h00, ZERO_RST},
		'{ADDR_MODEM_CTL, 1'h0, 8'h00, ZERO_RST}, '{ADDR_SCRATCH, 1'h0, 8'h00, SCRATCH_RST},
		'{ADDR_FEAT_CTL, 1'h0, 8'h00, ZERO_RST}, '{ADDR_ENH_FEAT, 1'h0, 8'h00, ZERO_RST},
		'{ADDR_TX_TRG, 1'h0, 8'h00, ZERO_RST}, '{ADDR_RX_TRG, 1'h0, 8'h00, ZERO_RST},
		'{ADDR_RESUME1, 1'h0, 8'h00, ZERO_RST}, '{ADDR_RESUME2, 1'h0, 8'h00, ZERO_RST},
		'{ADDR_PAUSE1, 1'h0, 8'h00, ZERO_RST}, '{ADDR_PAUSE2, 1'h0, 8'h00, ZERO_RST},
		'{ADDR_FLOW_STAT, 1'h0, 8'h00, ZERO_RST}, '{ADDR_MODEM_STAT, 1'h0, 8'h00, 8'ha0},
		'{ADDR_TX_CNT, 1'h0, 8'h00, 8'h07}, '{5'h1f, 1'h0, 8'h00, 8'h00},
		'{ADDR_SCRATCH, 1'h1, 8'h5a, 8'h5a}, '{ADDR_TX_CNT, 1'h1, 8'h55, 8'h07},
		'{5'h1f, 1'h1, 8'h33, 8'h00}, '{ADDR_RESUME1, 1'h1, 8'h11, 8'h11},
		'{ADDR_PAUSE2, 1'h1, 8'hc3, 8'hc3}, '{ADDR_HOLDING, 1'h1, 8'h77, 8'h3c},
		'{ADDR_FLOW_STAT, 1'h1, 8'h0f, 8'h00}};
	ufsr_regs u_dut (.ref_clk_in(ref_clk_in), .srst_in(srst_in), .por_in(por_in), .bus_in(bus),
		.rdata_out(rdata_out), .irq_status_in(irq_status_in), .line_status_in(line_status_in),
		.rx_data_in(rx_data_in), .tx_fifo_count_in(tx_fifo_count_in),
		.rx_fifo_count_in(rx_fifo_count_in), .flow_evt_in(flow_evt_in),
		.serial_tx_in(serial_tx_in), .modem_in(modem_in), .tx_out(tx_out),
		.rts_n_out(rts_n_out), .dtr_n_out(dtr_n_out), .tx_load_out(tx_load_out),
		.tx_data_out(tx_data_out), .flow_mode_out(flow_mode_out),
		.flow_status_out(flow_status_out));
	ufsr_host u_host (.ref_clk_in(ref_clk_in), .bus_out(bus), .rdata_in(rdata_out));
	// ----------------------------------------
	// clock, watchdog and reporting
	// ----------------------------------------
	initial begin
		ref_clk_in = 1'h0;
		forever #50 ref_clk_in = ~ref_clk_in;
	end
	task automatic stop_test();
		$display("compared %0d, mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : stop_test
	// whole run is under 150 cycles, so this ceiling leaves wide margin
	always @(posedge ref_clk_in) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			errors = errors + 1;
			$display("unexpected at %0t: run hung", $time);
			stop_test();
		end
	end
	task automatic check(input bit ok, input string msg);
		n_compared = n_compared + 1;
		if (!ok) begin
			errors = errors + 1;
			$display("unexpected at %0t: %s", $time, msg);
		end
	endtask : check
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		logic [7:0] x;
		u_host.access(1'h1, a, d, x);
	endtask : wr
	task automatic rd(input logic [4:0] a, input logic [7:0] e);
		logic [7:0] x;
		u_host.access(1'h0, a, 8'h00, x);
		`CHK(x, e);
	endtask : rd
	task automatic pulse(input ufsr_flow_evt_t e);
		@(negedge ref_clk_in);
		flow_evt_in = e;
		@(negedge ref_clk_in);
		flow_evt_in = '0;
	endtask : pulse
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		srst_in = 1'h1;
		por_in = 1'h1;
		serial_tx_in = 1'h0;
		// inputs differ from the reset values so a pass-through in reset shows up
		irq_status_in = 8'hc2;
		line_status_in = 8'h21;
		rx_data_in = 8'h3c;
		tx_fifo_count_in = 8'h07;
		rx_fifo_count_in = 8'h09;
		flow_evt_in = '0;
		modem_in = 4'ha;
		repeat (11) @(negedge ref_clk_in);
		`CHK({tx_out, rts_n_out, dtr_n_out}, 3'h7);
		`CHK(flow_status_out, 4'h0);
		@(negedge ref_clk_in);
		srst_in = 1'h0;
		por_in = 1'h0;
		$display("test reset done");
		foreach (rows[i]) begin
			if (rows[i].w) wr(rows[i].a, rows[i].d);
			rd(rows[i].a, rows[i].e);
		end
		`CHK(tx_data_out, 8'h77);
		$display("test table done");
		// holding write: load strobe stands for exactly one cycle
		wr(ADDR_HOLDING, 8'h96);
		`CHK({tx_load_out, tx_data_out}, {1'h1, 8'h96});
		@(negedge ref_clk_in);
		`CHK(tx_load_out, 1'h0);
		$display("test holding done");
		// reset pin alone must leave the divisor latches alone
		wr(ADDR_DIV_LOW, 8'h5a);
		wr(ADDR_DIV_HIGH, 8'h3c);
		wr(ADDR_MODEM_CTL, 8'h03);
		// modem pins follow the control register one edge later
		@(negedge ref_clk_in);
		`CHK({tx_out, rts_n_out, dtr_n_out}, 3'h0);
		@(negedge ref_clk_in);
		srst_in = 1'h1;
		modem_in = 4'h5;
		@(negedge ref_clk_in);
		`CHK({tx_out, rts_n_out, dtr_n_out}, 3'h7);
		srst_in = 1'h0;
		rd(ADDR_DIV_LOW, 8'h5a);
		rd(ADDR_DIV_HIGH, 8'h3c);
		rd(ADDR_SCRATCH, SCRATCH_RST);
		rd(ADDR_MODEM_CTL, ZERO_RST);
		rd(ADDR_MODEM_STAT, 8'h50);
		$display("test pin reset done");
		pulse(4'h8);
		`CHK(flow_status_out, 4'h0);
		wr(ADDR_ENH_FEAT, 8'h0f);
		`CHK(flow_mode_out, 4'hf);
		for (int i = 0; i < 4; i++) begin
			pulse(4'h1 << i);
			`CHK(flow_status_out, 4'h1 << i);
			rd(ADDR_FLOW_STAT, 8'h01 << i);
			rd(ADDR_FLOW_STAT, 8'h00);
		end
		// event in the read cycle survives the clear
		fork
			pulse(4'h2);
			rd(ADDR_FLOW_STAT, 8'h00);
		join
		`CHK(flow_status_out, 4'h2);
		rd(ADDR_FLOW_STAT, 8'h02);
		pulse(4'h8);
		pulse(4'h4);
		`CHK(flow_status_out, 4'h4);
		pulse(4'h2);
		pulse(4'h1);
		`CHK(flow_status_out, 4'h5);
		wr(ADDR_ENH_FEAT, 8'h00);
		@(negedge ref_clk_in);
		`CHK(flow_status_out, 4'h0);
		rd(ADDR_FLOW_STAT, 8'h00);
		$display("test flow status done");
		stop_test();
	end
endmodule : uart_flow_status_and_reset_state_tb
